// ---- hdl/lia_pkg.sv ----
// Shared constants for the icon, annunciator and output control block
package lia_pkg;
	// ------------------------------------------------------------
	// Register offsets on the annunciator address port
	// ------------------------------------------------------------
	localparam logic [3:0] LIA_ADDR_ANN_A   = 4'h0;
	localparam logic [3:0] LIA_ADDR_ANN_B   = 4'h1;
	localparam logic [3:0] LIA_ADDR_ANN_C   = 4'h2;
	localparam logic [3:0] LIA_ADDR_DIR     = 4'h4;
	localparam logic [7:0] LIA_REG_RESET    = 8'h00;
	localparam int         LIA_DIR_ROW_BIT  = 1;
	localparam int         LIA_DIR_COL_BIT  = 0;
	localparam int         LIA_LED_LSB      = 0;
	localparam int         LIA_PORT_LSB     = 3;
	localparam int         LIA_NUM_LED      = 3;
	localparam int         LIA_NUM_ANN      = 12;
	localparam int         LIA_ANN_PER_REG  = 4;

	// ------------------------------------------------------------
	// Panel geometry
	// ------------------------------------------------------------
	localparam int         LIA_NUM_ROWS     = 34;
	localparam int         LIA_NUM_COLS     = 60;
	localparam int         LIA_CHAR_ROWS    = 32;
	localparam int         LIA_FONT_W       = 6;
	localparam int         LIA_ICON_SPAN    = 24;
	localparam logic [5:0] LIA_ROW_ICON1    = 6'h20;
	localparam logic [5:0] LIA_ROW_ICON2    = 6'h21;
	localparam logic [5:0] LIA_LAST_COL     = 6'h3b;
	localparam logic [2:0] LIA_LAST_DOT     = 3'h5;
	localparam logic [2:0] LIA_CURSOR_RASTER = 3'h7;
	localparam logic [2:0] LIA_ICON2_BASE   = 3'h4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         LIA_CLK_MHZ      = 25;
	localparam int         LIA_FRAME_US     = 16000;
	localparam int         LIA_FRAME_CYCLES = LIA_FRAME_US * LIA_CLK_MHZ;
	localparam int         LIA_BLINK_BITS   = 6;

	typedef enum logic [4:0] {
		LIA_ST_IDLE  = 5'h01,
		LIA_ST_CODE  = 5'h02,
		LIA_ST_GLYPH = 5'h04,
		LIA_ST_SHIFT = 5'h08,
		LIA_ST_LATCH = 5'h10
	} lia_state_t;
endpackage

// ---- hdl/lia_ann_if.sv ----
// Carrier between the scan controller and the static annunciator driver
`timescale 1ns/1ps
`default_nettype none
interface lia_ann_if;
	logic       wr_en;
	logic [3:0] wr_addr;
	logic [7:0] wr_data;
	logic       frame_tick;
	logic       blink_phase;

	modport ctrl (
		output wr_en,
		output wr_addr,
		output wr_data,
		output frame_tick,
		output blink_phase
	);
	modport ann (
		input wr_en,
		input wr_addr,
		input wr_data,
		input frame_tick,
		input blink_phase
	);
endinterface
`default_nettype wire

// ---- hdl/lia_annunciator.sv ----
// Static annunciator driver with per-segment blink
`timescale 1ns/1ps
`default_nettype none
module lia_annunciator
	import lia_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	lia_ann_if.ann                      bus,
	output var  logic                   static_icon_backplane,
	output var  logic [LIA_NUM_ANN-1:0] static_icon_drive
);
	// ------------------------------------------------------------
	// Annunciator registers
	// ------------------------------------------------------------
	logic [7:0] ann_reg [3];
	logic [LIA_NUM_ANN-1:0] lit;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ann_reg[0] <= LIA_REG_RESET;
			ann_reg[1] <= LIA_REG_RESET;
			ann_reg[2] <= LIA_REG_RESET;
		end else if (ce && bus.wr_en) begin
			if (bus.wr_addr == LIA_ADDR_ANN_A)
				ann_reg[0] <= bus.wr_data;
			if (bus.wr_addr == LIA_ADDR_ANN_B)
				ann_reg[1] <= bus.wr_data;
			if (bus.wr_addr == LIA_ADDR_ANN_C)
				ann_reg[2] <= bus.wr_data;
		end
	end

	// ------------------------------------------------------------
	// Bit pairs: even bit lights, odd bit blinks
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < LIA_NUM_ANN; i++) begin : g_seg
			localparam int R = i / LIA_ANN_PER_REG;
			localparam int D = 6 - 2 * (i % LIA_ANN_PER_REG);
			assign lit[i] = ann_reg[R][D] &&
				!(ann_reg[R][D+1] && bus.blink_phase);
		end
	endgenerate

	wire next_backplane = bus.frame_tick ? !static_icon_backplane
	                                     : static_icon_backplane;

	// Drive runs in standby so marks stay visible
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			static_icon_backplane <= 1'b0;
			static_icon_drive     <= '0;
		end else if (ce) begin
			static_icon_backplane <= next_backplane;
			// Same edge as the flip, so a lit mark never loses contrast
			static_icon_drive <= {LIA_NUM_ANN{next_backplane}} ^ lit;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/lia_output_ctrl.sv ----
// Row/column scan, icon mapping, annunciator and lamp outputs
`timescale 1ns/1ps
`default_nettype none
module lia_output_ctrl
	import lia_pkg::*;
#(
	parameter int FRAME_CYCLES = LIA_FRAME_CYCLES
)
(
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	input  wire logic                    ann_wr_en,
	input  wire logic [3:0]              ann_wr_addr,
	input  wire logic [7:0]              ann_wr_data,
	input  wire logic                    led_wr_en,
	input  wire logic [7:0]              led_wr_data,
	input  wire logic                    icon_wr_en,
	input  wire logic [2:0]              icon_wr_addr,
	input  wire logic [7:0]              icon_wr_data,
	input  wire logic                    display_on,
	input  wire logic                    standby,
	input  wire logic                    sleep,
	input  wire logic [1:0]              line_count,
	input  wire logic                    cursor_on,
	input  wire logic                    ext_clk_sel,
	input  wire logic [6:0]              cursor_address_counter,
	output var  logic [6:0]              code_addr,
	input  wire logic [7:0]              code_data,
	output var  logic [11:0]             glyph_addr,
	input  wire logic [5:0]              glyph_data,
	output var  logic [LIA_NUM_ROWS-1:0] row_drive_out,
	output var  logic [LIA_NUM_COLS-1:0] column_drive_out,
	output var  logic                    static_icon_backplane,
	output var  logic [LIA_NUM_ANN-1:0]  static_icon_drive,
	output var  logic [LIA_NUM_LED-1:0]  lamp_out,
	output var  logic [LIA_NUM_LED-1:0]  general_out,
	output var  logic                    osc_enable
);
	// ------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------
	function automatic logic [5:0] row_pin(input logic [5:0] row,
	                                       input logic       rev);
		if (row >= LIA_ROW_ICON1)
			row_pin = (rev ^ (row == LIA_ROW_ICON2)) ?
				LIA_ROW_ICON2 : LIA_ROW_ICON1;
		else
			row_pin = rev ? 6'(LIA_CHAR_ROWS - 1 - int'(row)) : row;
	endfunction

	function automatic logic is_icon_row(input logic [5:0] row);
		is_icon_row = (row >= LIA_ROW_ICON1);
	endfunction

	// ------------------------------------------------------------
	// Host-side registers
	// ------------------------------------------------------------
	logic       column_scan_reverse;
	logic       row_scan_reverse;
	logic [5:0] led_and_port_outputs_reg;
	logic [5:0] icon_ram [8];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			column_scan_reverse <= 1'b0;
			row_scan_reverse    <= 1'b0;
		end else if (ce && ann_wr_en && ann_wr_addr == LIA_ADDR_DIR) begin
			row_scan_reverse    <= ann_wr_data[LIA_DIR_ROW_BIT];
			column_scan_reverse <= ann_wr_data[LIA_DIR_COL_BIT];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			led_and_port_outputs_reg <= LIA_REG_RESET[5:0];
		else if (ce && led_wr_en)
			led_and_port_outputs_reg <= led_wr_data[5:0];
	end

	// Icon memory has its own write port; scan reads never wait on it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < 8; k++)
				icon_ram[k] <= LIA_REG_RESET[5:0];
		end else if (ce && icon_wr_en) begin
			icon_ram[icon_wr_addr] <= icon_wr_data[5:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lamp_out    <= '1;
			general_out <= '0;
			osc_enable  <= 1'b0;
		end else if (ce) begin
			lamp_out    <= ~led_and_port_outputs_reg[LIA_LED_LSB +: LIA_NUM_LED];
			general_out <= led_and_port_outputs_reg[LIA_PORT_LSB +: LIA_NUM_LED];
			osc_enable  <= !standby && !ext_clk_sel;
		end
	end

	// ------------------------------------------------------------
	// Frame timebase and blink phase
	// ------------------------------------------------------------
	logic [23:0]               frame_cnt;
	logic                      frame_tick;
	logic [LIA_BLINK_BITS-1:0] blink_cnt;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			frame_cnt  <= '0;
			frame_tick <= 1'b0;
			blink_cnt  <= '0;
		end else if (ce) begin
			frame_tick <= (frame_cnt == 24'(FRAME_CYCLES - 1));
			if (frame_cnt == 24'(FRAME_CYCLES - 1))
				frame_cnt <= '0;
			else
				frame_cnt <= frame_cnt + 24'h000001;
			if (frame_tick)
				blink_cnt <= blink_cnt + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// Static annunciator driver
	// ------------------------------------------------------------
	lia_ann_if ann_bus ();

	assign ann_bus.wr_en       = ann_wr_en;
	assign ann_bus.wr_addr     = ann_wr_addr;
	assign ann_bus.wr_data     = ann_wr_data;
	assign ann_bus.frame_tick  = frame_tick;
	assign ann_bus.blink_phase = blink_cnt[LIA_BLINK_BITS-1];

	lia_annunciator u_ann (
		.mclk                  (mclk),
		.rst                   (rst),
		.ce                    (ce),
		.bus                   (ann_bus.ann),
		.static_icon_backplane (static_icon_backplane),
		.static_icon_drive     (static_icon_drive)
	);

	// ------------------------------------------------------------
	// Scan datapath decode
	// ------------------------------------------------------------
	lia_state_t  state;
	logic [5:0]  row;
	logic [5:0]  col;
	logic [2:0]  dot;
	logic [3:0]  chr;
	logic [5:0]  pat;
	logic [LIA_NUM_COLS-1:0] shreg;

	wire         display_active = display_on && !standby && !sleep;
	wire  [5:0]  last_char_row  = {1'b0, line_count, 3'h7};
	wire  [6:0]  next_code_addr = {1'b0, row[4:3], 4'(chr + 4'h1)};
	wire  [5:0]  icon_k         = (col < 6'(LIA_ICON_SPAN)) ? col :
	                              (col < 6'(2 * LIA_ICON_SPAN)) ?
	                              6'(col - 6'(LIA_ICON_SPAN)) :
	                              6'(col - 6'(2 * LIA_ICON_SPAN));
	wire  [2:0]  icon_word      = (row == LIA_ROW_ICON2 ? LIA_ICON2_BASE : 3'h0)
	                              + 3'(icon_k / 6'(LIA_FONT_W));
	wire  [2:0]  icon_bit       = 3'(5 - int'(icon_k % 6'(LIA_FONT_W)));
	wire  [5:0]  icon_sel       = icon_ram[icon_word];
	wire         scan_bit       = is_icon_row(row) ? icon_sel[icon_bit]
	                                               : pat[3'h5 - dot];
	wire         cursor_here    = cursor_on &&
	                              code_addr == cursor_address_counter &&
	                              row[2:0] == LIA_CURSOR_RASTER;
	wire  [LIA_NUM_COLS-1:0] next_shreg = column_scan_reverse ?
	                              {shreg[LIA_NUM_COLS-2:0], scan_bit} :
	                              {scan_bit, shreg[LIA_NUM_COLS-1:1]};
	wire  [5:0]  next_row       = (row == last_char_row) ? LIA_ROW_ICON1
	                                                     : row + 6'h01;

	// ------------------------------------------------------------
	// Scan state machine
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state      <= LIA_ST_IDLE;
			row        <= '0;
			col        <= '0;
			dot        <= '0;
			chr        <= '0;
			pat        <= '0;
			shreg      <= '0;
			code_addr  <= '0;
			glyph_addr <= '0;
		end else if (ce) begin
			if (!display_active) begin
				state <= LIA_ST_IDLE;
			end else begin
				case (state)
				LIA_ST_IDLE: begin
					row       <= '0;
					col       <= '0;
					dot       <= '0;
					chr       <= '0;
					code_addr <= '0;
					if (frame_tick)
						state <= LIA_ST_CODE;
				end
				LIA_ST_CODE: begin
					// Code for code_addr is on code_data this cycle
					glyph_addr <= {code_data, 1'b0, row[2:0]};
					state      <= LIA_ST_GLYPH;
				end
				LIA_ST_GLYPH: begin
					pat   <= glyph_data | {6{cursor_here}};
					dot   <= '0;
					state <= LIA_ST_SHIFT;
				end
				LIA_ST_SHIFT: begin
					shreg <= next_shreg;
					col   <= col + 6'h01;
					dot   <= (dot == LIA_LAST_DOT) ? 3'h0 : dot + 3'h1;
					if (col == LIA_LAST_COL) begin
						state <= LIA_ST_LATCH;
					end else if (!is_icon_row(row) && dot == LIA_LAST_DOT) begin
						chr       <= chr + 4'h1;
						code_addr <= next_code_addr;
						state     <= LIA_ST_CODE;
					end
				end
				LIA_ST_LATCH: begin
					col <= '0;
					dot <= '0;
					chr <= '0;
					row <= next_row;
					if (row == LIA_ROW_ICON2) begin
						state <= LIA_ST_IDLE;
					end else begin
						code_addr <= {1'b0, next_row[4:3], 4'h0};
						// Icon rows need no fetch, so shifting starts at once
						state <= is_icon_row(next_row) ? LIA_ST_SHIFT
						                               : LIA_ST_CODE;
					end
				end
				default: state <= LIA_ST_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Driver outputs
	// ------------------------------------------------------------
	// All-ones stands for supply level on every driver
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			row_drive_out    <= '1;
			column_drive_out <= '1;
		end else if (ce) begin
			if (!display_active) begin
				row_drive_out    <= '1;
				column_drive_out <= '1;
			end else if (state == LIA_ST_LATCH) begin
				column_drive_out <= next_shreg_hold(shreg);
				row_drive_out    <= LIA_NUM_ROWS'(1) <<
					row_pin(row, row_scan_reverse);
			end else if (state == LIA_ST_IDLE && row_drive_out == '1) begin
				row_drive_out    <= '0;
				column_drive_out <= '0;
			end
		end
	end

	function automatic logic [LIA_NUM_COLS-1:0] next_shreg_hold(
		input logic [LIA_NUM_COLS-1:0] v);
		next_shreg_hold = v;
	endfunction
endmodule
`default_nettype wire

// ---- tb/lia_output_ctrl_sva.sv ----
// Port-level assertions for the output control block
`timescale 1ns/1ps
`default_nettype none
module lia_output_ctrl_sva
	import lia_pkg::*;
(
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic                    ce,
	input wire logic                    led_wr_en,
	input wire logic [7:0]              led_wr_data,
	input wire logic                    display_on,
	input wire logic                    standby,
	input wire logic                    sleep,
	input wire logic                    ext_clk_sel,
	input wire logic [6:0]              code_addr,
	input wire logic [11:0]             glyph_addr,
	input wire logic [LIA_NUM_ROWS-1:0] row_drive_out,
	input wire logic [LIA_NUM_COLS-1:0] column_drive_out,
	input wire logic                    static_icon_backplane,
	input wire logic [LIA_NUM_LED-1:0]  lamp_out,
	input wire logic [LIA_NUM_LED-1:0]  general_out,
	input wire logic                    osc_enable
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_lamp_inverse: assert property (
		(led_wr_en && ce) ##1 ce ##1 ce |-> lamp_out == ~$past(led_wr_data[2:0], 2))
		else $error("lamp pins not inverse of written bits");
	a_port_follow: assert property (
		(led_wr_en && ce) ##1 ce ##1 ce |-> general_out == $past(led_wr_data[5:3], 2))
		else $error("general pins do not follow written bits");
	a_blank_inactive: assert property (
		(ce && !(display_on && !standby && !sleep))
		|=> (&row_drive_out && &column_drive_out))
		else $error("drivers not at supply level while inactive");
	a_row_onehot: assert property (
		$onehot0(row_drive_out) || &row_drive_out)
		else $error("more than one row selected");
	a_osc_follow: assert property (
		(ce && !rst) |=> osc_enable == (!$past(standby) && !$past(ext_clk_sel)))
		else $error("oscillator enable wrong");
	a_backplane_hold: assert property (
		$changed(static_icon_backplane) |=> $stable(static_icon_backplane)[*8])
		else $error("backplane toggles too fast");
	a_glyph_addr_fmt: assert property (
		glyph_addr[3] == 1'b0 && code_addr[6] == 1'b0)
		else $error("glyph or code address format wrong");
	a_blank_cols: assert property (
		&row_drive_out |-> &column_drive_out)
		else $error("columns driven while rows blank");
	a_ce_freeze: assert property (
		!ce |=> $stable(lamp_out) && $stable(general_out)
			&& $stable(row_drive_out) && $stable(osc_enable))
		else $error("state moved with clock enable low");
endmodule

bind lia_output_ctrl lia_output_ctrl_sva lia_output_ctrl_sva_i (
	.mclk(mclk), .rst(rst), .ce(ce), .led_wr_en(led_wr_en),
	.led_wr_data(led_wr_data), .display_on(display_on), .standby(standby),
	.sleep(sleep), .ext_clk_sel(ext_clk_sel), .code_addr(code_addr),
	.glyph_addr(glyph_addr), .row_drive_out(row_drive_out),
	.column_drive_out(column_drive_out),
	.static_icon_backplane(static_icon_backplane),
	.lamp_out(lamp_out), .general_out(general_out), .osc_enable(osc_enable));
`default_nettype wire

// ---- tb/lia_panel_model.sv ----
// Character memory and glyph memory seen by the scan logic
`timescale 1ns/1ps
`default_nettype none
module lia_panel_model (
	input  wire logic [6:0]  code_addr,
	output var  logic [7:0]  code_data,
	input  wire logic [11:0] glyph_addr,
	output var  logic [5:0]  glyph_data
);
	logic [5:0] pat;

	// Code at address a is 0x40 + a
	assign code_data = 8'h40 + {1'b0, code_addr};
	// Eighth raster stored as zero for the cursor
	assign pat = (glyph_addr[2:0] == 3'h7) ? 6'h00
		: glyph_addr[9:4] ^ {2{glyph_addr[2:0]}};
	// Bad bit 3 returns garbage so a misaddressed fetch shows
	assign glyph_data = glyph_addr[3] ? ~pat : pat;
endmodule
`default_nettype wire

// ---- tb/lia_output_ctrl_tb.sv ----
// Self-checking bench for the output control block
`timescale 1ns/1ps
`default_nettype none
module lia_output_ctrl_tb;
	import lia_pkg::*;
	localparam int FC = 1000;
	logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1;
	logic        ann_wr_en = 1'b0, led_wr_en = 1'b0, icon_wr_en = 1'b0;
	logic [3:0]  ann_wr_addr = 4'h0;
	logic [7:0]  ann_wr_data = 8'h00, led_wr_data = 8'h00;
	logic [7:0]  icon_wr_data = 8'h00;
	logic [2:0]  icon_wr_addr = 3'h0;
	logic        display_on = 1'b0, standby = 1'b0, sleep = 1'b0;
	logic        cursor_on = 1'b0, ext_clk_sel = 1'b0;
	logic [1:0]  line_count = 2'h0;
	logic [6:0]  cursor_address_counter = 7'h03, code_addr;
	logic [7:0]  code_data;
	logic [11:0] glyph_addr, static_icon_drive, lit;
	logic [5:0]  glyph_data;
	logic [33:0] row_drive_out;
	logic [59:0] column_drive_out;
	logic        static_icon_backplane, osc_enable;
	logic [2:0]  lamp_out, general_out;
	logic [7:0]  led_tab [3] = '{8'hc9, 8'h36, 8'h3f};
	int          miscompares = 0, total_checks = 0, n, bad;

	lia_output_ctrl #(.FRAME_CYCLES(FC)) lia_output_ctrl_i (
		.mclk(mclk), .rst(rst), .ce(ce), .ann_wr_en(ann_wr_en),
		.ann_wr_addr(ann_wr_addr), .ann_wr_data(ann_wr_data),
		.led_wr_en(led_wr_en), .led_wr_data(led_wr_data),
		.icon_wr_en(icon_wr_en), .icon_wr_addr(icon_wr_addr),
		.icon_wr_data(icon_wr_data), .display_on(display_on),
		.standby(standby), .sleep(sleep), .line_count(line_count),
		.cursor_on(cursor_on), .ext_clk_sel(ext_clk_sel),
		.cursor_address_counter(cursor_address_counter),
		.code_addr(code_addr), .code_data(code_data),
		.glyph_addr(glyph_addr), .glyph_data(glyph_data),
		.row_drive_out(row_drive_out), .column_drive_out(column_drive_out),
		.static_icon_backplane(static_icon_backplane),
		.static_icon_drive(static_icon_drive), .lamp_out(lamp_out),
		.general_out(general_out), .osc_enable(osc_enable));
	lia_panel_model lia_panel_model_i (.code_addr(code_addr),
		.code_data(code_data), .glyph_addr(glyph_addr),
		.glyph_data(glyph_data));

	always #20 mclk = ~mclk;

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// Kind 0 annunciator port, 1 lamp register, 2 icon memory
	task automatic wr(input int k, input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		ann_wr_en <= (k == 0);
		led_wr_en <= (k == 1);
		icon_wr_en <= (k == 2);
		ann_wr_addr <= a;
		icon_wr_addr <= a[2:0];
		ann_wr_data <= d;
		led_wr_data <= d;
		icon_wr_data <= d;
		@(posedge mclk);
		ann_wr_en <= 1'b0;
		led_wr_en <= 1'b0;
		icon_wr_en <= 1'b0;
	endtask

	task automatic wait_row(input logic [33:0] want, input logic [33:0] no);
		int i;
		i = 0;
		while (row_drive_out !== want && i < 20000) begin
			tick(1);
			i++;
			if ((row_drive_out & no) !== 34'h0 && row_drive_out !== '1)
				chk("deselected rows", 64'h0, row_drive_out & no);
		end
		if (i >= 20000) begin
			chk("row wait", want, row_drive_out);
			tally_and_finish();
		end
	endtask

	function automatic logic [7:0] iw(input int w);
		return 8'hc0 | ((8'(w) * 8'h0b + 8'h05) & 8'h3f);
	endfunction

	function automatic logic [59:0] char_cols(input logic [2:0] r,
		input int cur, input int base = 0);
		logic [59:0] v;
		logic [5:0]  p;
		for (int c = 0; c < 10; c++) begin
			p = (r == 3'h7) ? 6'h00 : 6'(base + c) ^ {r, r};
			if (r == 3'h7 && c == cur)
				p = 6'h3f;
			for (int d = 0; d < 6; d++)
				v[6 * c + d] = p[5 - d];
		end
		return v;
	endfunction

	function automatic logic [59:0] icon_cols(input int base);
		logic [59:0] v;
		logic [7:0]  d;
		int          q;
		for (int k = 0; k < 60; k++) begin
			q = (k < 48) ? k % 24 : k - 48;
			d = iw(base + q / 6);
			v[k] = d[5 - q % 6];
		end
		return v;
	endfunction

	function automatic logic [59:0] rev(input logic [59:0] v);
		logic [59:0] r;
		for (int k = 0; k < 60; k++)
			r[59 - k] = v[k];
		return r;
	endfunction

	initial begin
		tick(3);
		chk("lamp reset", 64'h7, lamp_out);
		chk("port reset", 64'h0, general_out);
		chk("rows reset", {34{1'b1}}, row_drive_out);
		@(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(1, 4'h0, led_tab[i]);
			tick(2);
			chk("lamp", 3'(~led_tab[i][2:0]), lamp_out);
			chk("port", led_tab[i][5:3], general_out);
		end
		// Writes with the clock enable low must be dropped
		@(posedge mclk);
		ce <= 1'b0;
		wr(1, 4'h0, 8'h00);
		tick(2);
		chk("frozen lamp", 64'h0, lamp_out);
		@(posedge mclk);
		ce <= 1'b1;
		ext_clk_sel <= 1'b1;
		tick(2);
		chk("osc ext clk", 64'h0, osc_enable);
		@(posedge mclk);
		ext_clk_sel <= 1'b0;
		tick(2);
		chk("osc run", 64'h1, osc_enable);
		for (int w = 0; w < 8; w++)
			wr(2, 4'(w), iw(w));
		@(posedge mclk);
		display_on <= 1'b1;
		wait_row(34'h1, 34'h0);
		chk("row 0 cols", char_cols(3'h0, -1), column_drive_out);
		wait_row(34'h1 << 32, 34'h0ffffff00);
		chk("icon row 1", icon_cols(0), column_drive_out);
		wait_row(34'h1 << 33, 34'h0);
		chk("icon row 2", icon_cols(4), column_drive_out);
		@(posedge mclk);
		cursor_on <= 1'b1;
		wait_row(34'h80, 34'h0);
		chk("cursor raster", char_cols(3'h7, 3), column_drive_out);
		@(posedge mclk);
		cursor_on <= 1'b0;
		wr(0, LIA_ADDR_DIR, 8'hff);
		wait_row(34'h1 << 31, 34'h0);
		chk("reversed row 0", rev(char_cols(3'h0, -1)), column_drive_out);
		wait_row(34'h1 << 33, 34'h0);
		chk("reversed icon", rev(icon_cols(0)), column_drive_out);
		// Two text lines, reversed: row 8 lands on pin 23
		@(posedge mclk);
		line_count <= 2'h1;
		wait_row(34'h1 << 23, 34'h00000ffff);
		chk("second line", rev(char_cols(3'h0, -1, 16)), column_drive_out);
		@(posedge mclk);
		sleep <= 1'b1;
		tick(2);
		chk("sleep cols", {60{1'b1}}, column_drive_out);
		@(posedge mclk);
		sleep <= 1'b0;
		standby <= 1'b1;
		tick(2);
		chk("standby rows", {34{1'b1}}, row_drive_out);
		chk("osc standby", 64'h0, osc_enable);
		// Annunciators keep running in standby; address 3 is unmapped
		wr(0, LIA_ADDR_ANN_A, 8'h01);
		wr(0, LIA_ADDR_ANN_B, 8'hc0);
		wr(0, 4'h3, 8'hff);
		tick(2);
		n = 0;
		bad = 0;
		for (int i = 0; i < 64 * FC; i++) begin
			tick(1);
			lit = static_icon_drive ^ {12{static_icon_backplane}};
			if (lit[4] === 1'b1)
				n++;
			if ((lit & 12'hfef) !== 12'h008)
				bad++;
		end
		// Apart from the blinking segment 4, segment 3 must stay lit and all others dark on every cycle
		chk("steady segments", 64'h1, bad == 0);
		chk("blink duty", 64'h1, n > 30 * FC && n < 34 * FC);
		tally_and_finish();
	end
endmodule
`default_nettype wire
